// *** shared/asp_regs.vh ***
// Constants for the converter serial port pin logic
// Summary of operation
// - The data-out/ready pin goes low when a conversion completes and a new result waits.
// - An unread result lets the ready indication go high again before the next update.
// - With chip select low, output bits change on serial clock falls for the host to sample on rises.
// - The output shift register loads from any internal data or control register for readout.
// - Bits shifted in on the data input go to the control or config register named by the last command byte; status and data are read only.
// - The clock pin either carries the internal oscillator out or takes an external clock in.
// - Serial traffic counts only while chip select is low, and chip select high ends any frame and returns to the command byte.
// - A low filter sync input asserts the filter reset output and forces ready high.
`ifndef ASP_REGS_VH
`define ASP_REGS_VH

// ==========================================
// Command byte fields
`define ASP_CMD_WEN_BIT 7
`define ASP_CMD_RD_BIT 6
`define ASP_CMD_SEL_MSB 5
`define ASP_CMD_LEN 5'h08

// ==========================================
// Register select codes and lengths in bits
`define ASP_SEL_STATUS 6'h00
`define ASP_SEL_CTRL 6'h01
`define ASP_SEL_DATA 6'h02
`define ASP_SEL_CFG 6'h03
`define ASP_LEN_STATUS 5'h08
`define ASP_LEN_CTRL 5'h10
`define ASP_LEN_DATA 5'h18
`define ASP_LEN_CFG 5'h10
`define ASP_LEN_OTHER 5'h08

// ==========================================
// Reset values and field positions
`define ASP_CTRL_RST 16'h0000
`define ASP_CFG_RST 16'h0000
`define ASP_DATA_RST 24'h00_0000
`define ASP_CTRL_EXTCLK_BIT 0

// ==========================================
// Internal oscillator: half period in ref_clk cycles
`define ASP_OSC_HALF 4'h4

`endif

// *** verilog/asp_serial_port.v ***
// Serial port, ready pin and clock pin logic of the converter
`timescale 1ns/10ps
`default_nettype none
`include "asp_regs.vh"

// ==========================================
// Pin synchroniser: change taken once stages two and three agree
module asp_sync #(
    parameter RST = 1'b0
) (
    input wire ref_clk,
    input wire rstn,
    input wire d,
    output reg q
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= RST;
            s2 <= RST;
            s3 <= RST;
            q <= RST;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q <= s3;
            end
        end
    end
endmodule

// ==========================================
// Top
module asp_serial_port (
    input wire ref_clk,
    input wire rstn,
    input wire sclk,
    input wire cs_n,
    input wire din,
    input wire sync_n,
    input wire clk_pin_in,
    input wire conv_done,
    input wire [23:0] conv_result,
    input wire update_soon,
    output reg dout_rdy,
    output reg dout_oe,
    output reg clk_pin_out,
    output reg clk_pin_oe,
    output reg conv_tick,
    output reg filter_rst,
    output reg [15:0] ctrl_reg,
    output reg [15:0] cfg_reg
);
    localparam ST_CMD = 2'b00;
    localparam ST_WR = 2'b01;
    localparam ST_RD = 2'b10;

    wire sclk_f;
    wire cs_n_f;
    wire din_f;
    wire sync_n_f;
    wire ext_f;
    reg sclk_d;
    reg ext_d;
    reg [1:0] state;
    reg [4:0] cnt;
    reg [4:0] len;
    reg [7:0] cmd_sh;
    reg [5:0] sel;
    reg [23:0] in_sh;
    reg [23:0] out_sh;
    reg out_bit;
    reg rdy_n;
    reg [23:0] data_reg;
    reg [3:0] osc_cnt;
    reg osc;
    wire rd_clear;
    wire rise;
    wire fall;
    wire [7:0] cmd_next;
    wire [23:0] in_next;

    // Idle-high reset level, so a select tied low sees no false rise
    asp_sync #(.RST(1'b1)) u_sclk (.ref_clk(ref_clk), .rstn(rstn), .d(sclk), .q(sclk_f));
    asp_sync #(.RST(1'b1)) u_cs (.ref_clk(ref_clk), .rstn(rstn), .d(cs_n), .q(cs_n_f));
    asp_sync #(.RST(1'b0)) u_din (.ref_clk(ref_clk), .rstn(rstn), .d(din), .q(din_f));
    asp_sync #(.RST(1'b1)) u_syn (.ref_clk(ref_clk), .rstn(rstn), .d(sync_n), .q(sync_n_f));
    asp_sync #(.RST(1'b0)) u_ext (.ref_clk(ref_clk), .rstn(rstn), .d(clk_pin_in), .q(ext_f));

    // Edges counted only inside a frame, so bursts may pause freely
    assign rise = sclk_f & ~sclk_d & ~cs_n_f;
    assign fall = ~sclk_f & sclk_d & ~cs_n_f;
    assign cmd_next = {cmd_sh[6:0], din_f};
    assign in_next = {in_sh[22:0], din_f};
    // Same edge as the last data bit, so a result landing then still wins
    assign rd_clear = rise & (state == ST_RD) & (cnt == len - 5'h01) & (sel == `ASP_SEL_DATA);

    // ==========================================
    // Register lengths and read values
    function [4:0] reg_len;
        input [5:0] s;
        begin
            case (s)
                `ASP_SEL_STATUS: reg_len = `ASP_LEN_STATUS;
                `ASP_SEL_CTRL: reg_len = `ASP_LEN_CTRL;
                `ASP_SEL_DATA: reg_len = `ASP_LEN_DATA;
                `ASP_SEL_CFG: reg_len = `ASP_LEN_CFG;
                default: reg_len = `ASP_LEN_OTHER;
            endcase
        end
    endfunction

    // Left aligned so the MSB always leaves from bit 23
    function [23:0] reg_val;
        input [5:0] s;
        input [15:0] c;
        input [15:0] g;
        input [23:0] d;
        input r;
        begin
            case (s)
                `ASP_SEL_STATUS: reg_val = {r, 23'h00_0000};
                `ASP_SEL_CTRL: reg_val = {c, 8'h00};
                `ASP_SEL_DATA: reg_val = d;
                `ASP_SEL_CFG: reg_val = {g, 8'h00};
                default: reg_val = 24'h00_0000;
            endcase
        end
    endfunction

    // ==========================================
    // Frame engine
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d <= 1'b1;
            state <= ST_CMD;
            cnt <= 5'h00;
            len <= `ASP_CMD_LEN;
            cmd_sh <= 8'h00;
            sel <= 6'h00;
            in_sh <= 24'h00_0000;
            out_sh <= 24'h00_0000;
            out_bit <= 1'b1;
            ctrl_reg <= `ASP_CTRL_RST;
            cfg_reg <= `ASP_CFG_RST;
        end else begin
            sclk_d <= sclk_f;
            if (cs_n_f) begin
                state <= ST_CMD;
                cnt <= 5'h00;
            end else if (rise) begin
                case (state)
                    ST_CMD: begin
                        cmd_sh <= cmd_next;
                        cnt <= cnt + 5'h01;
                        if (cnt == `ASP_CMD_LEN - 5'h01) begin
                            cnt <= 5'h00;
                            sel <= cmd_next[`ASP_CMD_SEL_MSB:0];
                            len <= reg_len(cmd_next[`ASP_CMD_SEL_MSB:0]);
                            // A set write-enable bit marks an idle byte
                            if (cmd_next[`ASP_CMD_WEN_BIT]) begin
                                state <= ST_CMD;
                            end else if (cmd_next[`ASP_CMD_RD_BIT]) begin
                                state <= ST_RD;
                                out_sh <= reg_val(cmd_next[`ASP_CMD_SEL_MSB:0], ctrl_reg,
                                    cfg_reg, data_reg, rdy_n);
                            end else begin
                                state <= ST_WR;
                            end
                        end
                    end
                    ST_WR: begin
                        in_sh <= in_next;
                        cnt <= cnt + 5'h01;
                        if (cnt == len - 5'h01) begin
                            cnt <= 5'h00;
                            state <= ST_CMD;
                            // Status and data are read only
                            if (sel == `ASP_SEL_CTRL) begin
                                ctrl_reg <= in_next[15:0];
                            end
                            if (sel == `ASP_SEL_CFG) begin
                                cfg_reg <= in_next[15:0];
                            end
                        end
                    end
                    ST_RD: begin
                        cnt <= cnt + 5'h01;
                        if (cnt == len - 5'h01) begin
                            cnt <= 5'h00;
                            state <= ST_CMD;
                        end
                    end
                    default: begin
                        state <= ST_CMD;
                    end
                endcase
            end else if (fall && state == ST_RD) begin
                out_bit <= out_sh[23];
                out_sh <= {out_sh[22:0], 1'b0};
            end
        end
    end

    // ==========================================
    // Ready flag, result latch, filter reset
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdy_n <= 1'b1;
            data_reg <= `ASP_DATA_RST;
            filter_rst <= 1'b1;
        end else begin
            filter_rst <= ~sync_n_f;
            if (!sync_n_f) begin
                rdy_n <= 1'b1;
            end else if (conv_done) begin
                // New result wins over a read finishing in the same cycle
                rdy_n <= 1'b0;
                data_reg <= conv_result;
            end else if (update_soon || rd_clear) begin
                rdy_n <= 1'b1;
            end
        end
    end

    // ==========================================
    // Shared pin and clock pin
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dout_rdy <= 1'b1;
            dout_oe <= 1'b0;
            ext_d <= 1'b0;
            osc_cnt <= 4'h0;
            osc <= 1'b0;
            clk_pin_out <= 1'b0;
            clk_pin_oe <= 1'b1;
            conv_tick <= 1'b0;
        end else begin
            dout_oe <= ~cs_n_f;
            dout_rdy <= (state == ST_RD) ? out_bit : rdy_n;
            ext_d <= ext_f;
            if (ctrl_reg[`ASP_CTRL_EXTCLK_BIT]) begin
                // Oscillator stopped, conversions follow the pin
                osc_cnt <= 4'h0;
                osc <= 1'b0;
                clk_pin_oe <= 1'b0;
                conv_tick <= ext_f & ~ext_d;
            end else begin
                clk_pin_oe <= 1'b1;
                if (osc_cnt == `ASP_OSC_HALF - 4'h1) begin
                    osc_cnt <= 4'h0;
                    osc <= ~osc;
                    conv_tick <= ~osc;
                end else begin
                    osc_cnt <= osc_cnt + 4'h1;
                    conv_tick <= 1'b0;
                end
            end
            clk_pin_out <= osc;
        end
    end
endmodule
`default_nettype wire

// *** tb/asp_serial_port_sva.sv ***
// Assertion checker for the converter serial port pins
`timescale 1ns/10ps
`default_nettype none
module asp_serial_port_sva (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sync_n,
    input wire logic clk_pin_in,
    input wire logic conv_done,
    input wire logic update_soon,
    input wire logic dout_rdy,
    input wire logic dout_oe,
    input wire logic clk_pin_out,
    input wire logic clk_pin_oe,
    input wire logic conv_tick,
    input wire logic filter_rst,
    input wire logic [15:0] ctrl_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ==========================
    // Ready and oscillator steps
    sequence s_done_idle;
        conv_done && !filter_rst && !dout_oe ##1 (!filter_rst && !dout_oe)[*2];
    endsequence
    sequence s_upd_idle;
        update_soon && !conv_done && !dout_oe ##1 (!dout_oe)[*2];
    endsequence
    sequence s_osc_cycle;
        clk_pin_out[*4] ##1 (!clk_pin_out)[*4];
    endsequence
    ready_low_a: assert property (s_done_idle |-> !dout_rdy)
        else $error("ready pin not low after conversion");
    ready_high_a: assert property (s_upd_idle |-> dout_rdy)
        else $error("ready pin not high before update");
    sync_ready_a: assert property (filter_rst && !dout_oe ##1
        filter_rst && !dout_oe |-> dout_rdy)
        else $error("ready pin low during filter sync");
    sync_rst_a: assert property (($stable(sync_n))[*6] |-> filter_rst == !sync_n)
        else $error("filter reset does not follow sync");
    oe_on_a: assert property ((!cs_n)[*8] |-> dout_oe)
        else $error("pin not driven while selected");
    oe_off_a: assert property ((cs_n)[*8] |-> !dout_oe)
        else $error("pin driven while deselected");
    osc_mode_a: assert property (($stable(ctrl_reg[0]))[*6] |->
        clk_pin_oe != ctrl_reg[0] && (clk_pin_oe || !clk_pin_out))
        else $error("clock pin mode wrong");
    osc_period_a: assert property (clk_pin_oe && $rose(clk_pin_out) |->
        (s_osc_cycle or ##[1:8] ctrl_reg[0]))
        else $error("oscillator period wrong");
    ext_tick_a: assert property (ctrl_reg[0] && $rose(clk_pin_in) |-> ##[2:8] conv_tick)
        else $error("no tick for external clock");
endmodule
bind asp_serial_port asp_serial_port_sva chk (.*);
`default_nettype wire

// *** tb/asp_host.sv ***
// Host model that frames the serial port
`timescale 1ns/10ps
`default_nettype none
module asp_host (
    input wire logic ref_clk,
    input wire logic dout_rdy,
    output var logic sclk = 1'b1,
    output var logic cs_n = 1'b1,
    output var logic din = 1'b0
);
    // ==========================
    // One frame, MSB first; gap stretches byte ends into bursts
    task automatic xfer(input logic [31:0] tx, input int n, gap, input bit hold,
        output logic [31:0] rx);
        rx = 32'h0;
        cs_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b0;
            din <= tx[i];
            repeat (4) @(posedge ref_clk);
            sclk <= 1'b1;
            // Late sample covers the pin synchroniser lag
            repeat (3) @(posedge ref_clk);
            rx = {rx[30:0], dout_rdy};
            repeat (i % 8 ? 1 : 1 + gap) @(posedge ref_clk);
        end
        din <= ~tx[0];
        cs_n <= !hold;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// *** tb/asp_serial_port_tb_top.sv ***
// Testbench top for the converter serial port pins
`timescale 1ns/10ps
`default_nettype none
module asp_serial_port_tb_top;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic sync_n = 1'b1;
    logic clk_pin_in = 1'b0;
    logic conv_done = 1'b0;
    logic update_soon = 1'b0;
    logic [23:0] conv_result = 24'h00_0000;
    wire logic sclk, cs_n, din, dout_rdy, dout_oe;
    wire logic clk_pin_out, clk_pin_oe, conv_tick, filter_rst;
    wire logic [15:0] ctrl_reg, cfg_reg;
    logic [31:0] seed = 32'h0000_b08e;
    logic [31:0] rx, v;
    int errors = 0;
    int cmp_count = 0;
    int ticks;
    asp_serial_port dut (.*);
    asp_host host (.*);
    initial forever #4 ref_clk = ~ref_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int blen(input logic [5:0] sel);
        return sel == 6'h02 ? 24 : (sel[0] && sel < 6'h04) ? 16 : 8;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic rd, input logic [5:0] sel, input logic [23:0] d,
        input int gap, input bit hold = 1'b0);
        int n;
        n = blen(sel);
        host.xfer(({25'h0, rd, sel} << n) | (d & ((32'h1 << n) - 1)), n + 8, gap, hold, rx);
        rx = rx & ((32'h1 << n) - 1);
    endtask
    task automatic done(input logic [23:0] r);
        conv_result <= r;
        conv_done <= 1'b1;
        cyc(1);
        conv_done <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk);
        $display("ERROR %0t: watchdog timeout", $time);
        errors++;
        give_verdict();
    end
    initial begin
        cyc(8);
        rstn <= 1'b1;
        cyc(8);
        // Random round trips; odd passes in bursts with chip select held
        for (int k = 0; k < 6; k++) begin
            v = rnd() & 32'hffff_fffe;
            acc(0, 6'h01, v[15:0], k);
            acc(0, 6'h03, v[31:16], 0, k[0]);
            acc(1, 6'h01, 0, 0, k[0]);
            chk(rx, v[15:0]);
            acc(1, 6'h03, 0, k);
            chk(rx, v[31:16]);
            chk({cfg_reg, ctrl_reg}, v);
        end
        acc(1, 6'h05, 0, 0);
        chk(rx, 0);
        $display("register test done");
        v = rnd();
        done(v[23:0]);
        for (ticks = 0; dout_rdy !== 1'b0 && ticks < 4; ticks++) cyc(1);
        chk(dout_rdy, 0);
        // Flag falls one cycle after the pulse, the pin one cycle later
        chk(ticks, 2);
        acc(1, 6'h00, 0, 0);
        chk(rx, 8'h00);
        acc(0, 6'h02, 24'hff_ffff, 0);
        acc(1, 6'h02, 0, 3);
        chk(rx, v[23:0]);
        chk(dout_rdy, 1);
        acc(1, 6'h00, 0, 0);
        chk(rx, 8'h80);
        done(~v[23:0]);
        cyc(3);
        update_soon <= 1'b1;
        cyc(1);
        update_soon <= 1'b0;
        cyc(3);
        chk(dout_rdy, 1);
        done(v[23:0]);
        cyc(3);
        sync_n <= 1'b0;
        cyc(8);
        done(v[23:0]);
        cyc(4);
        chk({filter_rst, dout_rdy}, 2'b11);
        sync_n <= 1'b1;
        cyc(8);
        chk(filter_rst, 0);
        $display("ready test done");
        ticks = 0;
        repeat (64) begin
            cyc(1);
            ticks += conv_tick;
        end
        chk(ticks, 8);
        acc(0, 6'h01, 16'h0001, 0);
        chk({clk_pin_oe, clk_pin_out}, 2'b00);
        ticks = 0;
        for (int i = 0; i < 80; i++) begin
            clk_pin_in <= i < 64 ? i[2] : 1'b0;
            cyc(1);
            ticks += conv_tick;
        end
        chk(ticks, 8);
        $display("clock test done");
        give_verdict();
    end
endmodule
`default_nettype wire
